// ### design/eic_bank.sv
// Event flags, interrupt enables and configuration bank on APB
//
// Overview of operation
// RULE_01: Enabled event raises interrupt request
// RULE_02: Enables live in three config registers
// RULE_03: Events in three registers, two counters
// RULE_04: Flags set regardless of enable
// RULE_05: Reading event register clears it
// RULE_06: One enable per event, incl. overflows; the software interrupt flag has no stored enable and never raises irq
// RULE_07: Accept register holds nine accept bits
// RULE_08: Accepted means frame data stored
// RULE_09: Accept and enable bits independent
// RULE_10: Enabled but unaccepted: interrupt, drop, zero length
// RULE_11: Five accept bits filter destination address
// RULE_12: One-shot bits act once, read zero
// RULE_13: Bits 5:0 carry register code
// RULE_14: Ten-bit counters clear on read
// RULE_15: Interrupt is OR of enabled pending
// RULE_16: Host reads events to drop interrupt
//
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
`include "eic_defines.svh"
module eic_bank (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receive side
  input wire logic rx_done,
  input wire eic_pkg::eic_rx_status_t rx_status,
  input wire eic_pkg::eic_rx_addr_t rx_addr,
  input wire logic [15:0] rx_len,
  input wire logic rx_missed,
  output logic rx_keep,
  output logic rx_drop,
  output logic [15:0] rx_len_out,
  // Transmit side
  input wire logic tx_done,
  input wire eic_pkg::eic_tx_status_t tx_status,
  input wire logic tx_coll,
  input wire logic [9:0] tx_cmd_bits,
  // Buffer events
  input wire eic_pkg::eic_buf_ev_t buf_ev,
  // Control outputs
  output logic irq,
  output logic soft_reset,
  output logic rx_dma_restart,
  output logic [15:0] rx_config,
  output logic [15:0] line_control,
  output logic [15:0] self_control,
  output logic [15:0] host_bus_control,
  output logic [15:0] test_control
);
  import eic_pkg::*;
  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  wire apb_setup = psel & ~penable;
  wire apb_done = psel & penable & pready_q;
  wire wr_done = apb_done & pwrite;
  wire rd_done = apb_done & ~pwrite;
  wire [9:0] idx = paddr[11:2];
  wire aligned = (paddr[1:0] == 2'h0);
  wire hit_rx_config = aligned & (idx == `EIC_IDX_RX_CFG);
  wire hit_rxacc = aligned & (idx == `EIC_IDX_RX_ACC);
  wire hit_tx_config = aligned & (idx == `EIC_IDX_TX_CFG);
  wire hit_tx_command_view = aligned & (idx == `EIC_IDX_TX_CMD);
  wire hit_buffer_config = aligned & (idx == `EIC_IDX_BUF_CFG);
  wire hit_line = aligned & (idx == `EIC_IDX_LINE);
  wire hit_self = aligned & (idx == `EIC_IDX_SELF);
  wire hit_bus = aligned & (idx == `EIC_IDX_BUS);
  wire hit_test = aligned & (idx == `EIC_IDX_TEST);
  wire hit_rxev = aligned & (idx == `EIC_IDX_RX_EV);
  wire hit_txev = aligned & (idx == `EIC_IDX_TX_EV);
  wire hit_bufev = aligned & (idx == `EIC_IDX_BUF_EV);
  wire hit_miss = aligned & (idx == `EIC_IDX_MISS);
  wire hit_coll = aligned & (idx == `EIC_IDX_COLL);
  wire mapped = hit_rx_config | hit_rxacc | hit_tx_config | hit_tx_command_view | hit_buffer_config |
                hit_line | hit_self | hit_bus | hit_test | hit_rxev |
                hit_txev | hit_bufev | hit_miss | hit_coll;
  wire [15:0] wdata = pwdata[15:0];
  wire wr_oneshot = wdata[`EIC_B_ONESHOT];
  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [15:0] rx_config_q;
  logic [15:0] rx_accept_control_q;
  logic [15:0] tx_config_q;
  logic [15:0] buffer_config_q;
  logic [15:0] line_control_q;
  logic [15:0] self_control_q;
  logic [15:0] host_bus_control_q;
  logic [15:0] test_control_q;
  // One-shot bits are never stored, so they read back as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_config_q <= `EIC_RST_CFG;
      rx_accept_control_q <= `EIC_RST_CFG;
      tx_config_q <= `EIC_RST_CFG;
      buffer_config_q <= `EIC_RST_CFG;
      line_control_q <= `EIC_RST_CFG;
      self_control_q <= `EIC_RST_CFG;
      host_bus_control_q <= `EIC_RST_CFG;
      test_control_q <= `EIC_RST_CFG;
    end else if (wr_done) begin
      if (hit_rx_config) rx_config_q <= wdata & `EIC_WM_RX_CFG; // [RULE_02] [RULE_12]
      if (hit_rxacc) rx_accept_control_q <= wdata & `EIC_WM_RX_ACC; // [RULE_07]
      if (hit_tx_config) tx_config_q <= wdata & `EIC_WM_TX_CFG; // [RULE_02]
      if (hit_buffer_config) buffer_config_q <= wdata & `EIC_WM_BUF_CFG; // [RULE_02] [RULE_12]
      if (hit_line) line_control_q <= wdata & `EIC_WM_PLAIN;
      if (hit_self) self_control_q <= wdata & `EIC_WM_ONESHOT; // [RULE_12]
      if (hit_bus) host_bus_control_q <= wdata & `EIC_WM_ONESHOT; // [RULE_12]
      if (hit_test) test_control_q <= wdata & `EIC_WM_PLAIN;
    end
  end
  // ----------------------------------------
  // One-shot actions
  // ----------------------------------------
  logic soft_reset_q;
  logic rx_dma_restart_q;
  logic skip_pend_q;
  wire skip_wr = wr_done & hit_rx_config & wr_oneshot;
  wire swint_wr = wr_done & hit_buffer_config & wr_oneshot;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_reset_q <= 1'b0;
      rx_dma_restart_q <= 1'b0;
      skip_pend_q <= 1'b0;
    end else begin
      soft_reset_q <= wr_done & hit_self & wr_oneshot; // [RULE_12]
      rx_dma_restart_q <= wr_done & hit_bus & wr_oneshot; // [RULE_12]
      // A skip request written in the frame-end cycle applies to the next frame
      skip_pend_q <= skip_wr | (skip_pend_q & ~rx_done); // [RULE_12]
    end
  end
  // ----------------------------------------
  // Event flag sets and read clears
  // ----------------------------------------
  logic [15:0] rx_set;
  logic [15:0] tx_set;
  logic [15:0] buf_set;
  logic [1:0] ovf_set;
  logic [15:0] rx_flags;
  logic [15:0] tx_flags;
  logic [15:0] buf_flags;
  logic [1:0] ovf_flags;
  logic [`EIC_CNT_W-1:0] miss_cnt_q;
  logic [`EIC_CNT_W-1:0] coll_cnt_q;
  logic [`EIC_NCOL_W-1:0] ncol_q;
  always_comb begin
    rx_set = '0;
    tx_set = '0;
    buf_set = '0;
    ovf_set = '0;
    rx_set[`EIC_RX_LONG] = rx_done & rx_status.extra; // [RULE_04]
    rx_set[`EIC_RX_SHORT] = rx_done & rx_status.runt;
    rx_set[`EIC_RX_CRC] = rx_done & rx_status.crc_err;
    rx_set[`EIC_RX_OK] = rx_done & rx_status.ok;
    tx_set[`EIC_TX_EXCESS] = tx_done & tx_status.excess; // [RULE_04]
    tx_set[`EIC_TX_JAB] = tx_done & tx_status.jabber;
    tx_set[`EIC_TX_OOW] = tx_done & tx_status.oow;
    tx_set[`EIC_TX_OK] = tx_done & tx_status.ok;
    tx_set[`EIC_TX_SQE] = tx_done & tx_status.sqe;
    tx_set[`EIC_TX_LOSS] = tx_done & tx_status.loss_crs;
    buf_set[`EIC_BF_DEST] = buf_ev.rx_dest; // [RULE_04]
    buf_set[`EIC_BF_R128] = buf_ev.rx128;
    buf_set[`EIC_BF_MISS] = rx_missed;
    buf_set[`EIC_BF_UNDER] = buf_ev.underrun;
    buf_set[`EIC_BF_RDY] = buf_ev.rdy4tx;
    buf_set[`EIC_BF_DMA] = buf_ev.dma_frame;
    buf_set[`EIC_BF_SWI] = swint_wr;
    ovf_set[`EIC_OVF_MISS] = rx_missed & (miss_cnt_q == `EIC_CNT_OVF); // [RULE_06]
    ovf_set[`EIC_OVF_COLL] = tx_coll & (coll_cnt_q == `EIC_CNT_OVF); // [RULE_06]
  end
  // Clear only event bits that the host actually saw in the captured word; each overflow flag clears on a read of its own counter
  wire rd_rxev = rd_done & hit_rxev;
  wire rd_txev = rd_done & hit_txev;
  wire rd_bufev = rd_done & hit_bufev;
  wire rd_miss = rd_done & hit_miss;
  wire rd_coll = rd_done & hit_coll;
  wire [15:0] rx_clr = rd_rxev ? prdata_q[15:0] & `EIC_RX_IE_MASK : '0; // [RULE_05]
  wire [15:0] tx_clr = rd_txev ? prdata_q[15:0] & `EIC_TX_IE_MASK : '0; // [RULE_05]
  wire [15:0] buf_clr = rd_bufev ? prdata_q[15:0] & `EIC_BUF_IE_MASK : '0; // [RULE_05]
  wire [1:0] ovf_clr = {rd_coll, rd_miss};
  eic_sticky #(.W(16)) u_rx_flags (
    .pclk(pclk), .presetn(presetn), .set(rx_set), .clr(rx_clr), .flags(rx_flags)
  );
  eic_sticky #(.W(16)) u_tx_flags (
    .pclk(pclk), .presetn(presetn), .set(tx_set), .clr(tx_clr), .flags(tx_flags)
  );
  eic_sticky #(.W(16)) u_buf_flags (
    .pclk(pclk), .presetn(presetn), .set(buf_set), .clr(buf_clr), .flags(buf_flags)
  );
  eic_sticky #(.W(2)) u_ovf_flags (
    .pclk(pclk), .presetn(presetn), .set(ovf_set), .clr(ovf_clr), .flags(ovf_flags)
  );
  // ----------------------------------------
  // Collision count field and statistics counters
  // ----------------------------------------
  wire [`EIC_NCOL_W-1:0] ncol_seen = rd_txev ? prdata_q[`EIC_TX_NCOL_LSB +: `EIC_NCOL_W] : '0;
  wire [`EIC_CNT_W-1:0] miss_seen = rd_miss ? prdata_q[`EIC_CNT_LSB +: `EIC_CNT_W] : '0;
  wire [`EIC_CNT_W-1:0] coll_seen = rd_coll ? prdata_q[`EIC_CNT_LSB +: `EIC_CNT_W] : '0;
  wire [`EIC_NCOL_W-1:0] ncol_left = ncol_q - ncol_seen;
  wire ncol_inc = tx_coll & (ncol_left != `EIC_NCOL_MAX);
  // Saturating field; the counters wrap and flag overflow instead
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ncol_q <= '0;
      miss_cnt_q <= '0;
      coll_cnt_q <= '0;
    end else begin
      ncol_q <= ncol_left + {{(`EIC_NCOL_W-1){1'b0}}, ncol_inc}; // [RULE_05] [RULE_06]
      miss_cnt_q <= miss_cnt_q - miss_seen + {{(`EIC_CNT_W-1){1'b0}}, rx_missed}; // [RULE_14]
      coll_cnt_q <= coll_cnt_q - coll_seen + {{(`EIC_CNT_W-1){1'b0}}, tx_coll}; // [RULE_14] [RULE_03]
    end
  end
  // ----------------------------------------
  // Interrupt request
  // ----------------------------------------
  logic irq_q;
  wire rx_pend = |(rx_flags & rx_config_q & `EIC_RX_IE_MASK); // [RULE_01]
  wire tx_pend = |(tx_flags & tx_config_q & `EIC_TX_IE_MASK); // [RULE_01]
  wire any_pend = tx_config_q[`EIC_TX_ANY] & (ncol_q != '0); // [RULE_06]
  wire buf_pend = |(buf_flags & buffer_config_q & `EIC_BUF_IE_MASK); // [RULE_01]
  wire ovf_pend = (buffer_config_q[`EIC_BF_MISSOVF] & ovf_flags[`EIC_OVF_MISS]) |
                  (buffer_config_q[`EIC_BF_COLOVF] & ovf_flags[`EIC_OVF_COLL]); // [RULE_06]
  wire irq_d = rx_pend | tx_pend | any_pend | buf_pend | ovf_pend; // [RULE_15]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d; // [RULE_15]
    end
  end
  // ----------------------------------------
  // Receive accept decision
  // ----------------------------------------
  logic rx_keep_q;
  logic rx_drop_q;
  logic [15:0] rx_len_q;
  wire [15:0] acc = rx_accept_control_q;
  // Enables play no part here: a frame may interrupt yet be dropped
  wire class_ok = (~rx_status.extra | acc[`EIC_RX_LONG]) &
                  (~rx_status.runt | acc[`EIC_RX_SHORT]) &
                  (~rx_status.crc_err | acc[`EIC_RX_CRC]) &
                  (~rx_status.ok | acc[`EIC_RX_OK]); // [RULE_09] [RULE_10]
  wire addr_ok = acc[`EIC_RX_PROM] |
                 (rx_addr.bcast & acc[`EIC_RX_BCAST]) |
                 (rx_addr.indiv & acc[`EIC_RX_INDIV]) |
                 (rx_addr.mcast & acc[`EIC_RX_MCAST]) |
                 (rx_addr.hash & acc[`EIC_RX_HASH]); // [RULE_11]
  wire keep = class_ok & addr_ok & ~skip_pend_q; // [RULE_08]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_keep_q <= 1'b0;
      rx_drop_q <= 1'b0;
      rx_len_q <= '0;
    end else begin
      rx_keep_q <= rx_done & keep; // [RULE_08]
      rx_drop_q <= rx_done & ~keep; // [RULE_10]
      if (rx_done) rx_len_q <= keep ? rx_len : '0; // [RULE_10]
    end
  end
  // ----------------------------------------
  // Read data and APB answer
  // ----------------------------------------
  logic [15:0] rd_word;
  always_comb begin
    if (hit_rx_config) rd_word = {rx_config_q[15:6], `EIC_CODE_RX_CFG}; // [RULE_13]
    else if (hit_rxacc) rd_word = {acc[15:6], `EIC_CODE_RX_ACC};
    else if (hit_tx_config) rd_word = {tx_config_q[15:6], `EIC_CODE_TX_CFG};
    else if (hit_tx_command_view) rd_word = {tx_cmd_bits, `EIC_CODE_TX_CMD};
    else if (hit_buffer_config) rd_word = {buffer_config_q[15:6], `EIC_CODE_BUF_CFG};
    else if (hit_line) rd_word = {line_control_q[15:6], `EIC_CODE_LINE};
    else if (hit_self) rd_word = {self_control_q[15:6], `EIC_CODE_SELF};
    else if (hit_bus) rd_word = {host_bus_control_q[15:6], `EIC_CODE_BUS};
    else if (hit_test) rd_word = {test_control_q[15:6], `EIC_CODE_TEST};
    else if (hit_rxev) rd_word = {rx_flags[15:6], `EIC_CODE_RX_EV}; // [RULE_03]
    else if (hit_txev) rd_word = {tx_flags[15], ncol_q, tx_flags[10:6], `EIC_CODE_TX_EV};
    else if (hit_bufev) rd_word = {buf_flags[15:6], `EIC_CODE_BUF_EV};
    else if (hit_miss) rd_word = {miss_cnt_q, `EIC_CODE_MISS}; // [RULE_14]
    else if (hit_coll) rd_word = {coll_cnt_q, `EIC_CODE_COLL};
    else rd_word = '0;
  end
  // Word is captured at setup; read clears act on that snapshot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= apb_setup;
      pslverr_q <= apb_setup & ~mapped;
      if (apb_setup & ~pwrite) prdata_q <= {16'h0000, rd_word};
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign rx_keep = rx_keep_q;
  assign rx_drop = rx_drop_q;
  assign rx_len_out = rx_len_q;
  assign soft_reset = soft_reset_q;
  assign rx_dma_restart = rx_dma_restart_q;
  assign rx_config = rx_config_q;
  assign line_control = line_control_q;
  assign self_control = self_control_q;
  assign host_bus_control = host_bus_control_q;
  assign test_control = test_control_q;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_irq_enabled;
    rx_done && rx_status.ok && rx_config_q[`EIC_RX_OK] && !wr_done |-> ##2 irq_q;
  endproperty
  a_irq_enabled: assert property (p_irq_enabled) else $error("enabled event gave no irq"); // [RULE_01]
  property p_flag_unmasked;
    rx_done && rx_status.crc_err && !rx_config_q[`EIC_RX_CRC] |=> rx_flags[`EIC_RX_CRC];
  endproperty
  a_flag_unmasked: assert property (p_flag_unmasked) else $error("masked event not flagged"); // [RULE_04]
  property p_read_clear;
    rd_rxev && prdata_q[`EIC_RX_OK] && !(rx_done && rx_status.ok) |=> !rx_flags[`EIC_RX_OK];
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("event not cleared by read"); // [RULE_05]
  property p_drop_zero;
    rx_done && rx_status.ok && !acc[`EIC_RX_OK] |=> rx_drop_q && !rx_keep_q && rx_len_q == 16'h0000;
  endproperty
  a_drop_zero: assert property (p_drop_zero) else $error("unaccepted frame not dropped"); // [RULE_10]
  property p_keep_len;
    rx_done && class_ok && acc[`EIC_RX_PROM] && !skip_pend_q |=> rx_keep_q && rx_len_q == $past(rx_len);
  endproperty
  a_keep_len: assert property (p_keep_len) else $error("accepted frame lost"); // [RULE_08]
  property p_oneshot_zero;
    apb_setup && !pwrite && (hit_self || hit_bus || hit_rx_config) |=> !prdata_q[`EIC_B_ONESHOT];
  endproperty
  a_oneshot_zero: assert property (p_oneshot_zero) else $error("one-shot bit read as one"); // [RULE_12]
  property p_code_cfg;
    apb_setup && !pwrite && hit_buffer_config |=> prdata_q[5:0] == `EIC_CODE_BUF_CFG && prdata_q[0];
  endproperty
  a_code_cfg: assert property (p_code_cfg) else $error("wrong register code"); // [RULE_13]
  property p_cnt_step;
    rx_missed && !rd_miss |=> miss_cnt_q == $past(miss_cnt_q) + 10'h001;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("missed counter did not step"); // [RULE_14]
  property p_ovf_irq;
    tx_coll && coll_cnt_q == `EIC_CNT_OVF && buffer_config_q[`EIC_BF_COLOVF] && !wr_done |-> ##2 irq_q;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow gave no irq"); // [RULE_06]
  property p_irq_quiet;
    rx_config_q == 16'h0000 && tx_config_q == 16'h0000 && buffer_config_q == 16'h0000 [*2] |=> !irq_q;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq with all enables clear"); // [RULE_15]
endmodule

// ### design/eic_defines.svh
// Constants for the event and interrupt configuration bank
`ifndef EIC_DEFINES_SVH
`define EIC_DEFINES_SVH
// ----------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------
`define EIC_IDX_RX_CFG 10'h102
`define EIC_IDX_RX_ACC 10'h104
`define EIC_IDX_TX_CFG 10'h106
`define EIC_IDX_TX_CMD 10'h108
`define EIC_IDX_BUF_CFG 10'h10A
`define EIC_IDX_LINE 10'h112
`define EIC_IDX_SELF 10'h114
`define EIC_IDX_BUS 10'h116
`define EIC_IDX_TEST 10'h118
`define EIC_IDX_RX_EV 10'h124
`define EIC_IDX_TX_EV 10'h128
`define EIC_IDX_BUF_EV 10'h12C
`define EIC_IDX_MISS 10'h130
`define EIC_IDX_COLL 10'h132
// ----------------------------------------
// Register codes in bits 5:0
// ----------------------------------------
`define EIC_CODE_RX_CFG 6'h03
`define EIC_CODE_RX_ACC 6'h05
`define EIC_CODE_TX_CFG 6'h07
`define EIC_CODE_TX_CMD 6'h09
`define EIC_CODE_BUF_CFG 6'h0B
`define EIC_CODE_LINE 6'h13
`define EIC_CODE_SELF 6'h15
`define EIC_CODE_BUS 6'h17
`define EIC_CODE_TEST 6'h19
`define EIC_CODE_RX_EV 6'h04
`define EIC_CODE_TX_EV 6'h08
`define EIC_CODE_BUF_EV 6'h0C
`define EIC_CODE_MISS 6'h10
`define EIC_CODE_COLL 6'h12
// ----------------------------------------
// Bit positions (shared by enable, accept and event words)
// ----------------------------------------
`define EIC_B_ONESHOT 6
`define EIC_RX_LONG 14
`define EIC_RX_SHORT 13
`define EIC_RX_CRC 12
`define EIC_RX_BCAST 11
`define EIC_RX_INDIV 10
`define EIC_RX_MCAST 9
`define EIC_RX_OK 8
`define EIC_RX_PROM 7
`define EIC_RX_HASH 6
`define EIC_TX_EXCESS 15
`define EIC_TX_ANY 11
`define EIC_TX_JAB 10
`define EIC_TX_OOW 9
`define EIC_TX_OK 8
`define EIC_TX_SQE 7
`define EIC_TX_LOSS 6
`define EIC_TX_NCOL_LSB 11
`define EIC_NCOL_W 4
`define EIC_NCOL_MAX 4'hF
`define EIC_BF_DEST 15
`define EIC_BF_MISSOVF 13
`define EIC_BF_COLOVF 12
`define EIC_BF_R128 11
`define EIC_BF_MISS 10
`define EIC_BF_UNDER 9
`define EIC_BF_RDY 8
`define EIC_BF_DMA 7
`define EIC_BF_SWI 6
`define EIC_CNT_LSB 6
`define EIC_CNT_W 10
`define EIC_CNT_OVF 10'h1FF
`define EIC_OVF_MISS 0
`define EIC_OVF_COLL 1
// ----------------------------------------
// Masks and reset values
// ----------------------------------------
`define EIC_RX_IE_MASK 16'h7100
`define EIC_TX_IE_MASK 16'h87C0
`define EIC_BUF_IE_MASK 16'h8FC0
`define EIC_WM_RX_CFG 16'h7F80
`define EIC_WM_RX_ACC 16'h7FC0
`define EIC_WM_TX_CFG 16'h8FC0
`define EIC_WM_BUF_CFG 16'hBF80
`define EIC_WM_PLAIN 16'hFFC0
`define EIC_WM_ONESHOT 16'hFF80
`define EIC_RST_CFG 16'h0000
`endif

// ### design/eic_pkg.sv
// Types carried between the bank and the MAC datapath
package eic_pkg;
  // ----------------------------------------
  // Receive frame status at end of frame
  // ----------------------------------------
  typedef struct packed {
    logic extra;
    logic runt;
    logic crc_err;
    logic ok;
  } eic_rx_status_t;
  // ----------------------------------------
  // Destination address class of the frame
  // ----------------------------------------
  typedef struct packed {
    logic bcast;
    logic indiv;
    logic mcast;
    logic hash;
  } eic_rx_addr_t;
  // ----------------------------------------
  // Transmit completion status
  // ----------------------------------------
  typedef struct packed {
    logic excess;
    logic jabber;
    logic oow;
    logic ok;
    logic sqe;
    logic loss_crs;
  } eic_tx_status_t;
  // ----------------------------------------
  // Buffer event pulses
  // ----------------------------------------
  typedef struct packed {
    logic rx_dest;
    logic rx128;
    logic underrun;
    logic rdy4tx;
    logic dma_frame;
  } eic_buf_ev_t;
endpackage

// ### design/eic_sticky.sv
// Sticky flag vector: set wins over clear
`timescale 1ns/10ps
module eic_sticky #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Flag control
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] flags
);
  logic [W-1:0] flags_q;
  logic [W-1:0] flags_d;
  assign flags_d = set | (flags_q & ~clr);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end
  assign flags = flags_q;
endmodule

// ### tb/eic_host.sv
// Host processor model: APB master for the bank
`timescale 1ns/10ps
module eic_host (
  // Clock
  input wire logic pclk,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // ----------------------------------------
  // One transfer; waits for pready, unbounded
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Request held until the sampling edge; only the bench watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ### tb/test_event_interrupt_config_bank.sv
// Register-level tests of the event and interrupt bank
`timescale 1ns/10ps
module test_event_interrupt_config_bank;
  import eic_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic rx_done = 1'b0, tx_coll = 1'b0, rx_missed = 1'b0, rx_keep, rx_drop, irq, soft_reset;
  eic_rx_status_t rx_status = 4'h0;
  logic [15:0] rx_len = 16'h0000, rx_len_out, rx_cfg_out;
  int miscompares = 0, num_checks = 0;
  always #2 pclk = ~pclk;
  eic_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  eic_bank u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_done(rx_done), .rx_status(rx_status), .rx_addr(4'h0),
    .rx_len(rx_len), .rx_missed(rx_missed), .rx_keep(rx_keep), .rx_drop(rx_drop),
    .rx_len_out(rx_len_out), .tx_done(1'b0), .tx_status(6'h00), .tx_coll(tx_coll),
    .tx_cmd_bits(10'h2A5), .buf_ev(5'h00), .irq(irq), .soft_reset(soft_reset),
    .rx_dma_restart(), .rx_config(rx_cfg_out), .line_control(), .self_control(), .host_bus_control(),
    .test_control());
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    u_host.xfer(1'b0, a, 32'h0, q, e);
    chk(q, x);
    chk(e, 1'b0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q, e);
  endtask
  // Frame end pulse; checks the answer in the following cycle
  task automatic frame(input logic k, input logic [15:0] len);
    @(posedge pclk);
    rx_status <= 4'h1;
    rx_len <= 16'h0040;
    rx_done <= 1'b1;
    @(posedge pclk);
    rx_done <= 1'b0;
    #1;
    chk({rx_keep, rx_drop}, {k, ~k});
    chk(rx_len_out, len);
    @(posedge pclk);
    #1;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #20000;
    miscompares++;
    complete_run;
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h408, 32'h0003);
    rd(12'h490, 32'h0004);
    rd(12'h420, 32'h0000_A949);
    u_host.xfer(1'b0, 12'h7FC, 32'h0, q, e);
    chk(q, 32'h0000_0000);
    chk(e, 1'b1);
    $display("test reset and map done");
    frame(1'b0, 16'h0000);
    chk(irq, 1'b0);
    rd(12'h490, 32'h0104);
    rd(12'h490, 32'h0004);
    $display("test flag without enable done");
    wr(12'h408, 32'h0100);
    frame(1'b0, 16'h0000);
    chk(irq, 1'b1);
    chk(rx_cfg_out, 32'h0000_0100);
    rd(12'h490, 32'h0104);
    @(posedge pclk);
    #1;
    chk(irq, 1'b0);
    $display("test enabled drop done");
    wr(12'h410, 32'h0180);
    rd(12'h410, 32'h0185);
    frame(1'b1, 16'h0040);
    chk(irq, 1'b1);
    rd(12'h490, 32'h0104);
    $display("test accepted frame done");
    wr(12'h450, 32'h0040);
    #1;
    chk(soft_reset, 1'b1);
    rd(12'h450, 32'h0015);
    $display("test one-shot done");
    repeat (3) begin
      @(posedge pclk);
      tx_coll <= 1'b1;
      @(posedge pclk);
      tx_coll <= 1'b0;
    end
    rd(12'h4C8, 32'h00D2);
    rd(12'h4C8, 32'h0012);
    $display("test collision counter done");
    wr(12'h428, 32'h2000);
    @(posedge pclk);
    rx_missed <= 1'b1;
    repeat (512) @(posedge pclk);
    rx_missed <= 1'b0;
    @(posedge pclk);
    #1;
    chk(irq, 1'b1);
    rd(12'h4C0, 32'h0000_8010);
    @(posedge pclk);
    #1;
    chk(irq, 1'b0);
    $display("test missed counter overflow done");
    complete_run;
  end
endmodule
